//--- logic/tension_pkg.sv
// Operation
// - The loop is held inactive while the enable setting is 0, runs while it is 1, and the setting resets to 0.
// - The loop can run only in the four vector control modes, never in the voltage-per-frequency modes.
// - Output reference selector 0 scales against the set tension and 1 against the maximum tension, default 0.
// - A full-scale regulator output equals the configured percentage (up to 50.0%, default 10.0%) of the chosen tension.
// - Feedback source codes are 0 keypad, 2 first analog, 3 second analog, 5 pulse, 6 bus word; 1 and 4 are reserved; default 2.
// - With bus feedback selected the loop reads the bus word at its dedicated address, which the remote master keeps written.
// - With keypad feedback selected the stored keypad percentage (0.0% to 100.0%, default 50.0%) is the feedback.
// - Every feedback channel is multiplied by a common gain of 0.00 to 10.00, default 1.00, before comparison.
// - A proportional gain of 0.000 to 8.000, default 0.500, scales the correction in proportion.
// - The error is integrated with an integral time of 0.0 s to 600.0 s, default 0.5 s; shorter time means stronger action.
package tension_pkg;
    localparam logic [15:0] ADDR_LOOP_ENABLE = 16'h504b;
    localparam logic [15:0] ADDR_OUT_REF_SELECT = 16'h504c;
    localparam logic [15:0] ADDR_OUT_MAX_PERCENT = 16'h504d;
    localparam logic [15:0] ADDR_FB_SOURCE = 16'h504e;
    localparam logic [15:0] ADDR_KEYPAD_FB = 16'h504f;
    localparam logic [15:0] ADDR_FB_GAIN = 16'h5050;
    localparam logic [15:0] ADDR_PROP_GAIN = 16'h5051;
    localparam logic [15:0] ADDR_INT_TIME = 16'h5052;
    localparam logic [15:0] ADDR_CONTROL_MODE = 16'h5060;
    localparam logic [15:0] ADDR_STATUS = 16'h5061;
    localparam logic [15:0] ADDR_PI_OUTPUT = 16'h5062;
    localparam logic [15:0] ADDR_CORRECTION = 16'h5063;
    localparam logic [15:0] ADDR_BUS_FEEDBACK = 16'h300e;

    localparam logic [15:0] RST_LOOP_ENABLE = 16'h0000;
    localparam logic [15:0] RST_OUT_REF_SELECT = 16'h0000;
    localparam logic [15:0] RST_OUT_MAX_PERCENT = 16'h0064;
    localparam logic [15:0] RST_FB_SOURCE = 16'h0002;
    localparam logic [15:0] RST_KEYPAD_FB = 16'h01f4;
    localparam logic [15:0] RST_FB_GAIN = 16'h0064;
    localparam logic [15:0] RST_PROP_GAIN = 16'h01f4;
    localparam logic [15:0] RST_INT_TIME = 16'h0005;
    localparam logic [15:0] RST_CONTROL_MODE = 16'h0001;

    localparam logic [15:0] MAX_LOOP_ENABLE = 16'h0001;
    localparam logic [15:0] MAX_OUT_REF_SELECT = 16'h0001;
    localparam logic [15:0] MAX_OUT_MAX_PERCENT = 16'h01f4;
    localparam logic [15:0] MAX_KEYPAD_FB = 16'h03e8;
    localparam logic [15:0] MAX_FB_GAIN = 16'h03e8;
    localparam logic [15:0] MAX_PROP_GAIN = 16'h1f40;
    localparam logic [15:0] MAX_INT_TIME = 16'h1770;
    localparam logic [15:0] MAX_CONTROL_MODE = 16'h0005;

    localparam logic [15:0] FB_SRC_KEYPAD = 16'h0000;
    localparam logic [15:0] FB_SRC_ANALOG1 = 16'h0002;
    localparam logic [15:0] FB_SRC_ANALOG2 = 16'h0003;
    localparam logic [15:0] FB_SRC_PULSE = 16'h0005;
    localparam logic [15:0] FB_SRC_BUS = 16'h0006;

    localparam logic [15:0] MODE_SENSORLESS_VECTOR = 16'h0001;
    localparam logic [15:0] MODE_CLOSED_LOOP_VECTOR = 16'h0002;
    localparam logic [15:0] MODE_PM_SENSORLESS_VECTOR = 16'h0004;
    localparam logic [15:0] MODE_PM_CLOSED_LOOP_VECTOR = 16'h0005;

    localparam int STATUS_ACTIVE_BIT = 0;
    localparam int STATUS_CLAMP_HIGH_BIT = 1;
    localparam int STATUS_CLAMP_LOW_BIT = 2;
    localparam int STATUS_MODE_OK_BIT = 3;

    localparam logic [31:0] FB_GAIN_UNIT = 32'd100;
    localparam logic [30:0] PROP_GAIN_UNIT = 31'd1000;
    localparam logic [47:0] PI_FULL_SCALE = 48'd1000;
    localparam logic [35:0] PERCENT_PRODUCT_UNIT = 36'd1000000;
    localparam int FRAC_BITS = 16;
    localparam int DIV_WIDTH = 48;

    localparam int CLK_FREQ_MHZ = 100;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES_DEFAULT = TICK_PERIOD_US * CLK_FREQ_MHZ;
    localparam int INT_TIME_UNIT_US = 100000;
    localparam logic [47:0] INT_DEN_SCALE = 48'(1000 * (INT_TIME_UNIT_US / TICK_PERIOD_US));

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [15:0] analog1;
        logic [15:0] analog2;
        logic [15:0] pulse;
    } fb_channels_t;

    typedef enum logic [1:0] {PI_IDLE, PI_DIVIDE, PI_UPDATE} pi_state_t;

    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (v > 32'h0000ffff) ? 16'hffff : v[15:0];
    endfunction : sat16

    function automatic logic [15:0] limit16(input logic [15:0] v, input logic [15:0] lim);
        limit16 = (v > lim) ? lim : v;
    endfunction : limit16
endpackage : tension_pkg

//--- logic/feedback_select.sv
`timescale 1ns/1ps
`default_nettype none
module feedback_select
    import tension_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [15:0] source,
    input wire logic [15:0] keypad_value,
    input wire logic [15:0] bus_word,
    input wire fb_channels_t channels,
    input wire logic [15:0] gain,
    output logic [15:0] feedback
);
    logic [15:0] raw;
    logic [31:0] scaled;
    logic [15:0] feedback_next;

    always_comb begin
        case (source)
            FB_SRC_KEYPAD: raw = keypad_value;
            FB_SRC_ANALOG1: raw = channels.analog1;
            FB_SRC_ANALOG2: raw = channels.analog2;
            FB_SRC_PULSE: raw = channels.pulse;
            FB_SRC_BUS: raw = bus_word;
            default: raw = 16'h0000;
        endcase
        // Gain applies after the mux so every channel shares it
        scaled = (32'(raw) * 32'(gain)) / FB_GAIN_UNIT;
        feedback_next = sat16(scaled);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            feedback <= 16'h0000;
        end else begin
            feedback <= feedback_next;
        end
    end
endmodule : feedback_select
`default_nettype wire

//--- logic/pi_divider.sv
`timescale 1ns/1ps
`default_nettype none
module pi_divider
    import tension_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [DIV_WIDTH-1:0] dividend,
    input wire logic [DIV_WIDTH-1:0] divisor,
    output logic [DIV_WIDTH-1:0] quotient,
    output logic done
);
    // Serial restoring divider: one bit per cycle keeps the area small,
    // the loop tick is far slower than the division latency
    logic [DIV_WIDTH:0] rem_reg, rem_next;
    logic [DIV_WIDTH-1:0] quo_reg, quo_next;
    logic [DIV_WIDTH-1:0] den_reg, den_next;
    logic [6:0] count_reg, count_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [DIV_WIDTH:0] trial;

    always_comb begin
        rem_next = rem_reg;
        quo_next = quo_reg;
        den_next = den_reg;
        count_next = count_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        trial = {rem_reg[DIV_WIDTH-1:0], quo_reg[DIV_WIDTH-1]};
        if (start) begin
            rem_next = '0;
            quo_next = dividend;
            den_next = divisor;
            count_next = 7'h00;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (trial >= {1'b0, den_reg}) begin
                rem_next = trial - {1'b0, den_reg};
                quo_next = {quo_reg[DIV_WIDTH-2:0], 1'b1};
            end else begin
                rem_next = trial;
                quo_next = {quo_reg[DIV_WIDTH-2:0], 1'b0};
            end
            count_next = count_reg + 7'h01;
            if (count_reg == 7'(DIV_WIDTH - 1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rem_reg <= '0;
            quo_reg <= '0;
            den_reg <= '0;
            count_reg <= 7'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            rem_reg <= rem_next;
            quo_reg <= quo_next;
            den_reg <= den_next;
            count_reg <= count_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign quotient = quo_reg;
    assign done = done_reg;
endmodule : pi_divider
`default_nettype wire

//--- logic/tension_pi_regulator.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tension_pi_regulator
    import tension_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire bus_req_t bus_req,
    output logic [15:0] rd_data,
    input wire logic drive_running,
    input wire logic [15:0] tension_reference,
    input wire logic [15:0] set_tension,
    input wire logic [15:0] max_tension,
    input wire fb_channels_t fb_channels,
    output logic [15:0] pi_output,
    output logic [15:0] tension_correction,
    output logic loop_active
);
    logic [15:0] loop_enable_reg, loop_enable_next;
    logic [15:0] out_ref_select_reg, out_ref_select_next;
    logic [15:0] out_max_percent_reg, out_max_percent_next;
    logic [15:0] fb_source_reg, fb_source_next;
    logic [15:0] keypad_fb_reg, keypad_fb_next;
    logic [15:0] fb_gain_reg, fb_gain_next;
    logic [15:0] prop_gain_reg, prop_gain_next;
    logic [15:0] int_time_reg, int_time_next;
    logic [15:0] control_mode_reg, control_mode_next;
    logic [15:0] bus_feedback_reg, bus_feedback_next;
    logic [15:0] rd_data_reg, rd_data_next;

    logic [31:0] tick_count_reg, tick_count_next;
    logic tick_reg, tick_next;

    pi_state_t state_reg, state_next;
    logic signed [47:0] acc_reg, acc_next;
    logic [15:0] pi_out_reg, pi_out_next;
    logic [15:0] corr_reg, corr_next;
    logic active_reg, active_next;
    logic clamp_high_reg, clamp_high_next;
    logic clamp_low_reg, clamp_low_next;
    logic err_neg_reg, err_neg_next;
    logic [30:0] prod_reg, prod_next;

    logic [15:0] feedback;
    logic mode_ok;
    logic run_ok;
    logic [15:0] status_word;
    logic div_start;
    logic [DIV_WIDTH-1:0] div_quotient;
    logic div_done;
    logic signed [17:0] err;
    logic [16:0] err_mag;
    logic signed [47:0] inc;
    logic signed [47:0] acc_try;
    logic signed [47:0] p_term;
    logic signed [47:0] sum;
    logic [15:0] ref_tension;
    logic [35:0] corr_wide;

    function automatic logic is_vector_mode(input logic [15:0] mode);
        is_vector_mode = (mode == MODE_SENSORLESS_VECTOR) || (mode == MODE_CLOSED_LOOP_VECTOR)
            || (mode == MODE_PM_SENSORLESS_VECTOR) || (mode == MODE_PM_CLOSED_LOOP_VECTOR);
    endfunction : is_vector_mode

    function automatic logic is_valid_source(input logic [15:0] src);
        is_valid_source = (src == FB_SRC_KEYPAD) || (src == FB_SRC_ANALOG1)
            || (src == FB_SRC_ANALOG2) || (src == FB_SRC_PULSE) || (src == FB_SRC_BUS);
    endfunction : is_valid_source

    assign mode_ok = is_vector_mode(control_mode_reg);
    assign run_ok = (loop_enable_reg == MAX_LOOP_ENABLE) && mode_ok;
    assign status_word = 16'({mode_ok, clamp_low_reg, clamp_high_reg, active_reg});

    feedback_select u_feedback_select (
        .sys_clk(sys_clk),
        .reset(reset),
        .source(fb_source_reg),
        .keypad_value(keypad_fb_reg),
        .bus_word(bus_feedback_reg),
        .channels(fb_channels),
        .gain(fb_gain_reg),
        .feedback(feedback)
    );

    // Register file
    always_comb begin
        loop_enable_next = loop_enable_reg;
        out_ref_select_next = out_ref_select_reg;
        out_max_percent_next = out_max_percent_reg;
        fb_source_next = fb_source_reg;
        keypad_fb_next = keypad_fb_reg;
        fb_gain_next = fb_gain_reg;
        prop_gain_next = prop_gain_reg;
        int_time_next = int_time_reg;
        control_mode_next = control_mode_reg;
        bus_feedback_next = bus_feedback_reg;
        rd_data_next = 16'h0000;
        if (bus_req.wr) begin
            case (bus_req.addr)
                // Stop-only settings are frozen while the drive runs
                ADDR_LOOP_ENABLE: begin
                    if (!drive_running) begin
                        loop_enable_next = limit16(bus_req.wdata, MAX_LOOP_ENABLE);
                    end
                end
                ADDR_OUT_REF_SELECT: begin
                    if (!drive_running) begin
                        out_ref_select_next = limit16(bus_req.wdata, MAX_OUT_REF_SELECT);
                    end
                end
                ADDR_OUT_MAX_PERCENT: out_max_percent_next = limit16(bus_req.wdata, MAX_OUT_MAX_PERCENT);
                ADDR_FB_SOURCE: begin
                    // Reserved codes leave the old source in place
                    if (is_valid_source(bus_req.wdata)) begin
                        fb_source_next = bus_req.wdata;
                    end
                end
                ADDR_KEYPAD_FB: keypad_fb_next = limit16(bus_req.wdata, MAX_KEYPAD_FB);
                ADDR_FB_GAIN: fb_gain_next = limit16(bus_req.wdata, MAX_FB_GAIN);
                ADDR_PROP_GAIN: prop_gain_next = limit16(bus_req.wdata, MAX_PROP_GAIN);
                ADDR_INT_TIME: int_time_next = limit16(bus_req.wdata, MAX_INT_TIME);
                ADDR_CONTROL_MODE: begin
                    if (!drive_running) begin
                        control_mode_next = limit16(bus_req.wdata, MAX_CONTROL_MODE);
                    end
                end
                ADDR_BUS_FEEDBACK: bus_feedback_next = bus_req.wdata;
                default: ;
            endcase
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_LOOP_ENABLE: rd_data_next = loop_enable_reg;
                ADDR_OUT_REF_SELECT: rd_data_next = out_ref_select_reg;
                ADDR_OUT_MAX_PERCENT: rd_data_next = out_max_percent_reg;
                ADDR_FB_SOURCE: rd_data_next = fb_source_reg;
                ADDR_KEYPAD_FB: rd_data_next = keypad_fb_reg;
                ADDR_FB_GAIN: rd_data_next = fb_gain_reg;
                ADDR_PROP_GAIN: rd_data_next = prop_gain_reg;
                ADDR_INT_TIME: rd_data_next = int_time_reg;
                ADDR_CONTROL_MODE: rd_data_next = control_mode_reg;
                ADDR_STATUS: rd_data_next = status_word;
                ADDR_PI_OUTPUT: rd_data_next = pi_out_reg;
                ADDR_CORRECTION: rd_data_next = corr_reg;
                ADDR_BUS_FEEDBACK: rd_data_next = bus_feedback_reg;
                default: rd_data_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            loop_enable_reg <= RST_LOOP_ENABLE;
            out_ref_select_reg <= RST_OUT_REF_SELECT;
            out_max_percent_reg <= RST_OUT_MAX_PERCENT;
            fb_source_reg <= RST_FB_SOURCE;
            keypad_fb_reg <= RST_KEYPAD_FB;
            fb_gain_reg <= RST_FB_GAIN;
            prop_gain_reg <= RST_PROP_GAIN;
            int_time_reg <= RST_INT_TIME;
            control_mode_reg <= RST_CONTROL_MODE;
            bus_feedback_reg <= 16'h0000;
            rd_data_reg <= 16'h0000;
        end else begin
            loop_enable_reg <= loop_enable_next;
            out_ref_select_reg <= out_ref_select_next;
            out_max_percent_reg <= out_max_percent_next;
            fb_source_reg <= fb_source_next;
            keypad_fb_reg <= keypad_fb_next;
            fb_gain_reg <= fb_gain_next;
            prop_gain_reg <= prop_gain_next;
            int_time_reg <= int_time_next;
            control_mode_reg <= control_mode_next;
            bus_feedback_reg <= bus_feedback_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // Control tick divider
    always_comb begin
        tick_next = 1'b0;
        tick_count_next = tick_count_reg + 32'd1;
        if (tick_count_reg >= 32'(TICK_CYCLES - 1)) begin
            tick_count_next = 32'd0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tick_count_reg <= 32'd0;
            tick_reg <= 1'b0;
        end else begin
            tick_count_reg <= tick_count_next;
            tick_reg <= tick_next;
        end
    end

    // Integral step = kp * e * Ts / Ti, kept with fractional bits in the accumulator
    assign div_start = (state_reg == PI_IDLE) && tick_reg && run_ok && (int_time_reg != 16'h0000);

    pi_divider u_pi_divider (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(div_start),
        .dividend({1'b0, prod_next, 16'h0000}),
        .divisor(48'(int_time_reg) * INT_DEN_SCALE),
        .quotient(div_quotient),
        .done(div_done)
    );

    assign err = $signed({2'b00, tension_reference}) - $signed({2'b00, feedback});
    assign err_mag = err[17] ? 17'(-err) : err[16:0];
    assign ref_tension = (out_ref_select_reg == MAX_OUT_REF_SELECT) ? max_tension : set_tension;

    always_comb begin
        state_next = state_reg;
        acc_next = acc_reg;
        pi_out_next = pi_out_reg;
        corr_next = corr_reg;
        active_next = run_ok;
        clamp_high_next = clamp_high_reg;
        clamp_low_next = clamp_low_reg;
        err_neg_next = err_neg_reg;
        prod_next = prod_reg;
        inc = '0;
        acc_try = '0;
        p_term = '0;
        sum = '0;
        corr_wide = '0;
        if (state_reg == PI_IDLE && tick_reg && run_ok) begin
            err_neg_next = err[17];
            prod_next = 31'(err_mag) * 31'(prop_gain_reg);
        end
        case (state_reg)
            PI_IDLE: begin
                if (tick_reg && run_ok) begin
                    // Zero integral time turns integral action off
                    state_next = (int_time_reg != 16'h0000) ? PI_DIVIDE : PI_UPDATE;
                end
            end
            PI_DIVIDE: begin
                if (div_done) begin
                    state_next = PI_UPDATE;
                end
            end
            PI_UPDATE: begin
                if (int_time_reg != 16'h0000) begin
                    inc = err_neg_reg ? -$signed(div_quotient) : $signed(div_quotient);
                end
                acc_try = acc_reg + inc;
                p_term = $signed(48'(prod_reg / PROP_GAIN_UNIT));
                if (err_neg_reg) begin
                    p_term = -p_term;
                end
                sum = p_term + (acc_try >>> FRAC_BITS);
                clamp_high_next = sum > $signed(PI_FULL_SCALE);
                clamp_low_next = sum < 0;
                if (clamp_high_next) begin
                    pi_out_next = PI_FULL_SCALE[15:0];
                end else if (clamp_low_next) begin
                    pi_out_next = 16'h0000;
                end else begin
                    pi_out_next = sum[15:0];
                end
                // Hold the integrator only when it would push further into the limit
                if (!((clamp_high_next && inc > 0) || (clamp_low_next && inc < 0))) begin
                    acc_next = acc_try;
                end
                corr_wide = (36'(ref_tension) * 36'(out_max_percent_reg) * 36'(pi_out_next))
                    / PERCENT_PRODUCT_UNIT;
                corr_next = corr_wide[15:0];
                state_next = PI_IDLE;
            end
            default: state_next = PI_IDLE;
        endcase
        if (!run_ok) begin
            state_next = PI_IDLE;
            acc_next = '0;
            pi_out_next = 16'h0000;
            corr_next = 16'h0000;
            clamp_high_next = 1'b0;
            clamp_low_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= PI_IDLE;
            acc_reg <= '0;
            pi_out_reg <= 16'h0000;
            corr_reg <= 16'h0000;
            active_reg <= 1'b0;
            clamp_high_reg <= 1'b0;
            clamp_low_reg <= 1'b0;
            err_neg_reg <= 1'b0;
            prod_reg <= '0;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            pi_out_reg <= pi_out_next;
            corr_reg <= corr_next;
            active_reg <= active_next;
            clamp_high_reg <= clamp_high_next;
            clamp_low_reg <= clamp_low_next;
            err_neg_reg <= err_neg_next;
            prod_reg <= prod_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign pi_output = pi_out_reg;
    assign tension_correction = corr_reg;
    assign loop_active = active_reg;
endmodule : tension_pi_regulator
`default_nettype wire

//--- testbench/tension_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module tension_sensor_model
    import tension_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [15:0] measured,
    output fb_channels_t channels
);
    // Distinct scale per channel so a wrong selection cannot pass unseen
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            channels <= '0;
        end else begin
            channels.analog1 <= measured;
            channels.analog2 <= measured >> 1;
            channels.pulse <= measured >> 2;
        end
    end
endmodule : tension_sensor_model
`default_nettype wire

//--- testbench/tension_pi_regulator_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tension_checker
    import tension_pkg::*;
#(parameter int TICK_CYCLES = 60) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire bus_req_t bus_req,
    input wire logic [15:0] rd_data,
    input wire logic drive_running,
    input wire logic [15:0] set_tension,
    input wire logic [15:0] max_tension,
    input wire logic [15:0] pi_output,
    input wire logic [15:0] tension_correction,
    input wire logic loop_active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence en_write;
        bus_req.wr && bus_req.addr == ADDR_LOOP_ENABLE && bus_req.wdata == 16'h0001 && !drive_running;
    endsequence
    sequence en_read;
        bus_req.rd && bus_req.addr == ADDR_LOOP_ENABLE;
    endsequence
    chk_rd_idle_zero: assert property (!bus_req.rd |=> rd_data == 16'h0000)
        else $error("read data not idle");
    chk_enable_readback: assert property (en_write ##1 en_read |=> rd_data == 16'h0001)
        else $error("enable readback wrong");
    chk_idle_output_zero: assert property (!loop_active [*2] |-> pi_output == 16'h0000)
        else $error("output while idle");
    chk_stop_hold: assert property (drive_running && loop_active |=> loop_active)
        else $error("loop dropped while running");
    chk_mode_gate: assert property (bus_req.wr && bus_req.addr == ADDR_CONTROL_MODE
        && bus_req.wdata == 16'h0000 && !drive_running |-> ##[1:3] !loop_active)
        else $error("loop active in plain mode");
    chk_pi_bounded: assert property (pi_output <= 16'h03e8)
        else $error("output above full scale");
    chk_corr_zero: assert property (pi_output == 16'h0000 |-> tension_correction == 16'h0000)
        else $error("correction without output");
    chk_corr_half: assert property (tension_correction
        <= ((set_tension > max_tension ? set_tension : max_tension) >> 1))
        else $error("correction above half");
endmodule : tension_checker
bind tension_pi_regulator tension_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.sys_clk(sys_clk),
    .reset(reset), .bus_req(bus_req), .rd_data(rd_data), .drive_running(drive_running),
    .set_tension(set_tension), .max_tension(max_tension), .pi_output(pi_output),
    .tension_correction(tension_correction), .loop_active(loop_active));
`default_nettype wire

//--- testbench/tension_pi_regulator_test.sv
`timescale 1ns/1ps
`default_nettype none
module tension_pi_regulator_test;
    import tension_pkg::*;
    logic sys_clk, reset, drive_running, loop_active;
    bus_req_t bus_req;
    fb_channels_t fb_channels;
    logic [15:0] rd_data, pi_output, tension_correction, measured, p0;
    int miscompares = 0;
    int tests_run = 0;
    logic [15:0] addrs [10] = '{ADDR_LOOP_ENABLE, ADDR_OUT_REF_SELECT, ADDR_OUT_MAX_PERCENT,
        ADDR_FB_SOURCE, ADDR_KEYPAD_FB, ADDR_FB_GAIN, ADDR_PROP_GAIN, ADDR_INT_TIME, 16'h504a, 16'h200e};
    logic [15:0] rsts [10] = '{16'h0000, 16'h0000, 16'h0064, 16'h0002, 16'h01f4, 16'h0064,
        16'h01f4, 16'h0005, 16'h0000, 16'h0000};
    logic [15:0] srcs [5] = '{16'h0000, 16'h0002, 16'h0003, 16'h0005, 16'h0006};
    logic [15:0] pis [5] = '{16'h0064, 16'h00c8, 16'h0190, 16'h01f4, 16'h012c};
    tension_pi_regulator #(.TICK_CYCLES(60)) dut (.sys_clk(sys_clk), .reset(reset),
        .bus_req(bus_req), .rd_data(rd_data), .drive_running(drive_running),
        .tension_reference(16'h0258), .set_tension(16'h07d0), .max_tension(16'h0fa0),
        .fb_channels(fb_channels), .pi_output(pi_output),
        .tension_correction(tension_correction), .loop_active(loop_active));
    tension_sensor_model partner (.sys_clk(sys_clk), .reset(reset), .measured(measured),
        .channels(fb_channels));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 cmp(rd_data, e);
        @(posedge sys_clk);
    endtask : rd
    task automatic wrd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] e);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        rd(a, e);
    endtask : wrd
    // 200 cycles, more than three ticks of 60 cycles: long enough for any update to land
    task automatic settle;
        repeat (200) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        reset = 1'b1;
        bus_req = '0;
        drive_running = 1'b0;
        measured = 16'h0190;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        foreach (addrs[i]) rd(addrs[i], rsts[i]);
        wrd(ADDR_OUT_MAX_PERCENT, 16'h0258, 16'h01f4);
        wrd(ADDR_FB_SOURCE, 16'h0004, 16'h0002);
        wrd(ADDR_FB_SOURCE, 16'h0001, 16'h0002);
        wrd(ADDR_PROP_GAIN, 16'h2328, 16'h1f40);
        wrd(ADDR_OUT_MAX_PERCENT, 16'h0064, 16'h0064);
        wrd(ADDR_PROP_GAIN, 16'h03e8, 16'h03e8);
        wrd(ADDR_INT_TIME, 16'h0000, 16'h0000);
        wrd(ADDR_BUS_FEEDBACK, 16'h012c, 16'h012c);
        wrd(ADDR_LOOP_ENABLE, 16'h0001, 16'h0001);
        drive_running <= 1'b1;
        wrd(ADDR_LOOP_ENABLE, 16'h0000, 16'h0001);
        wrd(ADDR_OUT_REF_SELECT, 16'h0001, 16'h0000);
        drive_running <= 1'b0;
        foreach (srcs[i]) begin
            wrd(ADDR_FB_SOURCE, srcs[i], srcs[i]);
            settle();
            cmp(pi_output, pis[i]);
            cmp(tension_correction, pis[i] / 5);
        end
        wrd(ADDR_OUT_REF_SELECT, 16'h0001, 16'h0001);
        settle();
        cmp(tension_correction, 16'h0078);
        wrd(ADDR_FB_GAIN, 16'h00c8, 16'h00c8);
        settle();
        cmp(pi_output, 16'h0000);
        wrd(ADDR_FB_GAIN, 16'h0064, 16'h0064);
        wrd(ADDR_PROP_GAIN, 16'h07d0, 16'h07d0);
        settle();
        cmp(pi_output, 16'h0258);
        wrd(ADDR_PROP_GAIN, 16'h1f40, 16'h1f40);
        wrd(ADDR_OUT_MAX_PERCENT, 16'h01f4, 16'h01f4);
        settle();
        cmp(pi_output, 16'h03e8);
        cmp(tension_correction, 16'h07d0);
        wrd(ADDR_PROP_GAIN, 16'h03e8, 16'h03e8);
        wrd(ADDR_INT_TIME, 16'h0005, 16'h0005);
        settle();
        p0 = pi_output;
        repeat (10) settle();
        cmp(16'(pi_output > p0), 16'h0001);
        for (int m = 0; m < 6; m++) begin
            wrd(ADDR_CONTROL_MODE, 16'(m), 16'(m));
            settle();
            cmp(16'(loop_active), 16'(m != 0 && m != 3));
        end
        wrd(ADDR_LOOP_ENABLE, 16'h0000, 16'h0000);
        settle();
        cmp(pi_output, 16'h0000);
        tally_and_finish();
    end
endmodule : tension_pi_regulator_test
`default_nettype wire
